// [pkg/hfts_pkg.sv]
// Package of register offsets, field positions and level steps for the HDLC FIFO control block
`default_nettype none
package hfts_pkg;
   // ----------------------------------------------------------------
   // Register offsets on the register page
   // ----------------------------------------------------------------
   localparam logic [4:0] OFS_TEST_STATUS = 5'h1c; // Read-only test status
   localparam logic [4:0] OFS_LEVEL_CTRL = 5'h1d; // FIFO full status levels
   localparam logic [4:0] OFS_THRESH_CTRL = 5'h1e; // FIFO interrupt thresholds
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int RX_SEL_LSB = 4; // Bits 6..4 of both control registers
   localparam int TX_SEL_LSB = 0; // Bits 2..0 of both control registers
   localparam int TST_RX_GATED_BIT_CLOCK_MIRROR_BIT = 3; // Gated receive bit clock mirror
   localparam int TST_TX_GATED_BIT_CLOCK_MIRROR_BIT = 2; // Gated transmit bit clock mirror
   localparam int TST_CRC_BIT = 1; // Frame check passed
   localparam int TST_ADDR_BIT = 0; // Address match
   // ----------------------------------------------------------------
   // Reset values and level steps
   // ----------------------------------------------------------------
   localparam logic [2:0] SEL_RESET = 3'h0; // All selector fields reset to 000
   localparam logic [7:0] FULL_STEP = 8'h10; // Full status level step, 16 bytes
   localparam logic [7:0] LOW_STEP = 8'h08; // Tx low threshold step, 8 bytes
   localparam logic [7:0] RXIRQ_BASE = 8'h40; // Rx full threshold base, 64 bytes
   localparam logic [7:0] RXIRQ_STEP = 8'h08; // Rx full threshold step, 8 bytes
endpackage
`default_nettype wire

// [design/hfts_fifo.sv]
// Small flip-flop FIFO with valid and ready on both sides
`default_nettype none
module hfts_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
   localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH]; // Storage words
   logic [AW-1:0] wr_ptr, next_wr_ptr; // Write index
   logic [AW-1:0] rd_ptr, next_rd_ptr; // Read index
   logic [CW-1:0] count, next_count; // Words held
   logic push, pop;
   logic next_in_ready, next_out_valid; // Handshake flags, registered so ports come from flops
   logic [WIDTH-1:0] next_out_data; // Head word for the next cycle

   // Pointer wrap handles depths that are not a power of two
   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == PTR_LAST) ? '0 : p + AW'(1);
   endfunction

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      push = in_valid && (count != CNT_FULL);
      pop = (count != '0) && out_ready;
      next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
      next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
      next_count = count;
      if (push && !pop) begin
         next_count = count + CW'(1);
      end else if (pop && !push) begin
         next_count = count - CW'(1);
      end
      // Ready and valid follow the next count, so a full FIFO stalls its source
      next_in_ready = (next_count != CNT_FULL);
      next_out_valid = (next_count != '0);
      // A word written straight into the head slot bypasses the storage read
      if (push && (wr_ptr == next_rd_ptr)) begin
         next_out_data = in_data;
      end else if (next_count != '0) begin
         next_out_data = mem[next_rd_ptr];
      end else begin
         next_out_data = out_data;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         in_ready <= next_in_ready;
         out_valid <= next_out_valid;
         out_data <= next_out_data;
      end
   end

   // Storage carries no reset; only held words are ever presented
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule
`default_nettype wire

// [design/hfts_top.sv]
// HDLC FIFO level selection, interrupt thresholds and test status for one controller
// How it works
// - Status bit 3 mirrors enabled receive bit clock
// - Status bit 2 mirrors enabled transmit bit clock
// - Status bit 1 shows frame check success
// - Status bit 0 shows address match
// - Status bits 7..4 reserved, read zero
// - Rx full level is 16 times code plus one
// - Tx full level is 16 times code plus one
// - Tx low threshold is 8 times code plus one
`default_nettype none
module hfts_top #(
   parameter int DATA_W = 8,
   parameter int FIFO_DEPTH = 4
) (
   input wire logic mclk,
   input wire logic rst_n,
   // Parallel register port, one page
   input wire logic reg_sel,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Engine status inputs
   input wire logic receiver_enable_bit,
   input wire logic transmitter_enable_bit,
   input wire logic rx_bit_clock,
   input wire logic tx_bit_clock,
   input wire logic rx_crc_ok,
   input wire logic rx_addr_match,
   input wire logic [7:0] rx_fifo_fill,
   input wire logic [7:0] tx_fifo_fill,
   // Level and interrupt condition outputs
   output logic rx_full_status,
   output logic tx_full_status,
   output logic rx_fifo_full_irq,
   output logic tx_fifo_low_irq,
   // Receive byte stream staging
   input wire logic rx_byte_valid,
   output logic rx_byte_ready,
   input wire logic [DATA_W-1:0] rx_byte_data,
   output logic rx_out_valid,
   input wire logic rx_out_ready,
   output logic [DATA_W-1:0] rx_out_data
);
   // ----------------------------------------------------------------
   // Level decoding helpers
   // ----------------------------------------------------------------
   // Full status level, 16 up to 128 bytes
   function automatic logic [7:0] full_level(input logic [2:0] code);
      full_level = 8'(({5'h0, code} + 8'h01) * hfts_pkg::FULL_STEP);
   endfunction

   // Tx low threshold, 8 up to 64 bytes
   function automatic logic [7:0] low_level(input logic [2:0] code);
      low_level = 8'(({5'h0, code} + 8'h01) * hfts_pkg::LOW_STEP);
   endfunction

   // Rx full threshold, 64 up to 120 bytes
   function automatic logic [7:0] rxirq_level(input logic [2:0] code);
      rxirq_level = 8'(hfts_pkg::RXIRQ_BASE + {5'h0, code} * hfts_pkg::RXIRQ_STEP);
   endfunction

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [2:0] rx_full_status_level_sel, next_rx_full_status_level_sel;
   logic [2:0] tx_full_status_level_sel, next_tx_full_status_level_sel;
   logic [2:0] rx_full_irq_threshold_sel, next_rx_full_irq_threshold_sel;
   logic [2:0] tx_low_irq_threshold_sel, next_tx_low_irq_threshold_sel;
   logic [7:0] next_reg_rdata; // Read data, registered one cycle after the strobe
   logic [7:0] status_byte; // Live test status
   logic wr_hit, rd_hit;

   // Bit clocks come from another domain, so each passes two flops first
   logic rx_clk_s1, rx_clk_s2;
   logic tx_clk_s1, tx_clk_s2;
   logic rx_gated_bit_clock_mirror, next_rx_gated_bit_clock_mirror;
   logic tx_gated_bit_clock_mirror, next_tx_gated_bit_clock_mirror;
   logic crc_s1, crc_s2, addr_s1, addr_s2;

   // Flag outputs
   logic next_rx_full_status, next_tx_full_status;
   logic next_rx_fifo_full_irq, next_tx_fifo_low_irq;

   // ----------------------------------------------------------------
   // Synchronisers for pins outside the clock domain
   // ----------------------------------------------------------------
   // Only the second stage is read, so a metastable first stage never reaches logic
   // A bit clock faster than half of mclk will alias in its mirror
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_clk_s1 <= 1'b0;
         rx_clk_s2 <= 1'b0;
         tx_clk_s1 <= 1'b0;
         tx_clk_s2 <= 1'b0;
         crc_s1 <= 1'b0;
         crc_s2 <= 1'b0;
         addr_s1 <= 1'b0;
         addr_s2 <= 1'b0;
      end else begin
         rx_clk_s1 <= rx_bit_clock;
         rx_clk_s2 <= rx_clk_s1;
         tx_clk_s1 <= tx_bit_clock;
         tx_clk_s2 <= tx_clk_s1;
         crc_s1 <= rx_crc_ok;
         crc_s2 <= crc_s1;
         addr_s1 <= rx_addr_match;
         addr_s2 <= addr_s1;
      end
   end

   // ----------------------------------------------------------------
   // Next values for registers, mirrors and flags
   // ----------------------------------------------------------------
   // Defaults first, so every next value is set on every path
   always_comb begin
      wr_hit = reg_sel && reg_wr;
      rd_hit = reg_sel && reg_rd;
      // Clocks are mirrored only while their direction is enabled
      next_rx_gated_bit_clock_mirror = rx_clk_s2 && receiver_enable_bit;
      next_tx_gated_bit_clock_mirror = tx_clk_s2 && transmitter_enable_bit;
      status_byte = 8'h00; // Upper nibble stays zero
      status_byte[hfts_pkg::TST_RX_GATED_BIT_CLOCK_MIRROR_BIT] = rx_gated_bit_clock_mirror;
      status_byte[hfts_pkg::TST_TX_GATED_BIT_CLOCK_MIRROR_BIT] = tx_gated_bit_clock_mirror;
      status_byte[hfts_pkg::TST_CRC_BIT] = crc_s2;
      status_byte[hfts_pkg::TST_ADDR_BIT] = addr_s2;
      next_rx_full_status_level_sel = rx_full_status_level_sel;
      next_tx_full_status_level_sel = tx_full_status_level_sel;
      next_rx_full_irq_threshold_sel = rx_full_irq_threshold_sel;
      next_tx_low_irq_threshold_sel = tx_low_irq_threshold_sel;
      // Writes keep only the selector fields; bits 7 and 3 are dropped
      if (wr_hit && reg_addr == hfts_pkg::OFS_LEVEL_CTRL) begin
         next_rx_full_status_level_sel = reg_wdata[hfts_pkg::RX_SEL_LSB +: 3];
         next_tx_full_status_level_sel = reg_wdata[hfts_pkg::TX_SEL_LSB +: 3];
      end
      if (wr_hit && reg_addr == hfts_pkg::OFS_THRESH_CTRL) begin
         next_rx_full_irq_threshold_sel = reg_wdata[hfts_pkg::RX_SEL_LSB +: 3];
         next_tx_low_irq_threshold_sel = reg_wdata[hfts_pkg::TX_SEL_LSB +: 3];
      end
      // Read mux; unmapped offsets answer zero
      next_reg_rdata = 8'h00;
      if (rd_hit) begin
         unique case (reg_addr)
            hfts_pkg::OFS_TEST_STATUS: begin
               next_reg_rdata = status_byte;
            end
            hfts_pkg::OFS_LEVEL_CTRL: begin
               next_reg_rdata = {1'b0, rx_full_status_level_sel,
                                 1'b0, tx_full_status_level_sel};
            end
            hfts_pkg::OFS_THRESH_CTRL: begin
               next_reg_rdata = {1'b0, rx_full_irq_threshold_sel,
                                 1'b0, tx_low_irq_threshold_sel};
            end
            default: begin
               next_reg_rdata = 8'h00;
            end
         endcase
      end
      // Fill comparisons use the stored selectors, so a new code acts next cycle
      next_rx_full_status = rx_fifo_fill >= full_level(rx_full_status_level_sel);
      next_tx_full_status = tx_fifo_fill >= full_level(tx_full_status_level_sel);
      next_tx_fifo_low_irq = tx_fifo_fill <= low_level(tx_low_irq_threshold_sel);
      next_rx_fifo_full_irq =
         rx_fifo_fill >= rxirq_level(rx_full_irq_threshold_sel);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Reset branch loads constants only; the selectors reset to 000
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_full_status_level_sel <= hfts_pkg::SEL_RESET;
         tx_full_status_level_sel <= hfts_pkg::SEL_RESET;
         rx_full_irq_threshold_sel <= hfts_pkg::SEL_RESET;
         tx_low_irq_threshold_sel <= hfts_pkg::SEL_RESET;
         rx_gated_bit_clock_mirror <= 1'b0;
         tx_gated_bit_clock_mirror <= 1'b0;
         reg_rdata <= 8'h00;
         rx_full_status <= 1'b0;
         tx_full_status <= 1'b0;
         rx_fifo_full_irq <= 1'b0;
         tx_fifo_low_irq <= 1'b0;
      end else begin
         rx_full_status_level_sel <= next_rx_full_status_level_sel;
         tx_full_status_level_sel <= next_tx_full_status_level_sel;
         rx_full_irq_threshold_sel <= next_rx_full_irq_threshold_sel;
         tx_low_irq_threshold_sel <= next_tx_low_irq_threshold_sel;
         rx_gated_bit_clock_mirror <= next_rx_gated_bit_clock_mirror;
         tx_gated_bit_clock_mirror <= next_tx_gated_bit_clock_mirror;
         reg_rdata <= next_reg_rdata;
         rx_full_status <= next_rx_full_status;
         tx_full_status <= next_tx_full_status;
         rx_fifo_full_irq <= next_rx_fifo_full_irq;
         tx_fifo_low_irq <= next_tx_fifo_low_irq;
      end
   end

   // ----------------------------------------------------------------
   // Receive byte staging FIFO
   // ----------------------------------------------------------------
   // Back-pressure: rx_byte_ready drops when all words are held
   hfts_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_stage (
      .mclk(mclk),
      .rst_n(rst_n),
      .in_valid(rx_byte_valid),
      .in_ready(rx_byte_ready),
      .in_data(rx_byte_data),
      .out_valid(rx_out_valid),
      .out_ready(rx_out_ready),
      .out_data(rx_out_data)
   );
endmodule
`default_nettype wire

// [tb/hfts_top_chk.sv]
// Checker of register reads, test status bits and level flags
`default_nettype none
module hfts_top_chk (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic reg_sel,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic receiver_enable_bit,
   input wire logic transmitter_enable_bit,
   input wire logic rx_bit_clock,
   input wire logic tx_bit_clock,
   input wire logic rx_crc_ok,
   input wire logic rx_addr_match,
   input wire logic [7:0] rx_fifo_fill,
   input wire logic [7:0] tx_fifo_fill,
   input wire logic rx_full_status,
   input wire logic tx_full_status,
   input wire logic rx_fifo_full_irq,
   input wire logic tx_fifo_low_irq
);
   logic [7:0] lvl; // Shadow of the level register, unused bits dropped
   logic [7:0] thr; // Shadow of the threshold register
   logic [5:0] pins; // Status pins, watched for stillness
   logic rd_st; // Read of the test status register
   assign pins = {receiver_enable_bit, transmitter_enable_bit, rx_bit_clock, tx_bit_clock,
      rx_crc_ok, rx_addr_match};
   assign rd_st = reg_sel && reg_rd && reg_addr == 5'h1c;
   // Mirror the write path so expected flags follow software
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lvl <= 8'h00;
         thr <= 8'h00;
      end else if (reg_sel && reg_wr) begin
         if (reg_addr == 5'h1d)
            lvl <= reg_wdata & 8'h77;
         if (reg_addr == 5'h1e)
            thr <= reg_wdata & 8'h77;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // The first edge after release still shows reset flags, hence the past reset guard
   chk_rx_level: assert property ($past(rst_n) |-> rx_full_status ==
      ($past(rx_fifo_fill) >= 16 * ($past(lvl[6:4]) + 1))) else $error("rx full flag wrong");
   chk_tx_level: assert property ($past(rst_n) |-> tx_full_status ==
      ($past(tx_fifo_fill) >= 16 * ($past(lvl[2:0]) + 1))) else $error("tx full flag wrong");
   chk_rx_thresh: assert property ($past(rst_n) |-> rx_fifo_full_irq ==
      ($past(rx_fifo_fill) >= 64 + 8 * $past(thr[6:4]))) else $error("rx irq flag wrong");
   chk_tx_thresh: assert property ($past(rst_n) |-> tx_fifo_low_irq ==
      ($past(tx_fifo_fill) <= 8 * ($past(thr[2:0]) + 1))) else $error("tx low flag wrong");
   chk_level_readback: assert property (
      reg_sel && reg_rd && reg_addr == 5'h1d |=> reg_rdata == $past(lvl))
      else $error("level register readback wrong");
   chk_thresh_readback: assert property (
      reg_sel && reg_rd && reg_addr == 5'h1e |=> reg_rdata == $past(thr))
      else $error("threshold register readback wrong");
   chk_status_rsvd: assert property (rd_st |=> reg_rdata[7:4] == 4'h0)
      else $error("status reserved bits set");
   // Pins must sit still long enough to cross the synchronisers
   chk_clk_mirror: assert property (
      $stable(pins) [*4] ##0 rd_st |=> reg_rdata[3:2] ==
      $past({pins[5] & pins[3], pins[4] & pins[2]})) else $error("clock mirror wrong");
   chk_check_flags: assert property (
      $stable(pins) [*4] ##0 rd_st |=> reg_rdata[1:0] == $past(pins[1:0]))
      else $error("frame or address status wrong");
   cover property (rd_st);
   cover property (rx_fifo_full_irq && rx_full_status);
   cover property (tx_fifo_low_irq && !tx_full_status);
endmodule
bind hfts_top hfts_top_chk u_chk (.mclk, .rst_n, .reg_sel, .reg_rd, .reg_wr, .reg_addr,
   .reg_wdata, .reg_rdata, .receiver_enable_bit, .transmitter_enable_bit, .rx_bit_clock,
   .tx_bit_clock, .rx_crc_ok, .rx_addr_match, .rx_fifo_fill, .tx_fifo_fill,
   .rx_full_status, .tx_full_status, .rx_fifo_full_irq, .tx_fifo_low_irq);
`default_nettype wire

// [tb/hdlc_fifo_threshold_test_status_tb.sv]
// Self-checking bench for the HDLC FIFO level and status block
`default_nettype none
module hdlc_fifo_threshold_test_status_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rst_n = 1'b0, reg_sel = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [7:0] reg_wdata = 8'h00, rx_fifo_fill = 8'h00, tx_fifo_fill = 8'h00;
   logic receiver_enable_bit = 1'b0, transmitter_enable_bit = 1'b0, rx_bit_clock = 1'b0;
   logic tx_bit_clock = 1'b0, rx_crc_ok = 1'b0, rx_addr_match = 1'b0, rx_out_ready = 1'b0;
   logic rx_byte_valid = 1'b0, rd_taken = 1'b0, in_stall = 1'b0;
   logic [7:0] rx_byte_data = 8'h00, reg_rdata, rx_out_data, r, lv, th, ef, flg;
   logic rx_full_status, tx_full_status, rx_fifo_full_irq, tx_fifo_low_irq;
   logic rx_byte_ready, rx_out_valid;
   logic [7:0] rq[$]; // Expected read data, oldest first
   logic [7:0] fq[$]; // Bytes accepted by the staging FIFO
   logic [7:0] eq[$]; // Expected flag bytes
   logic [1:0] hq[$]; // Expected {rx_out_valid, rx_byte_ready}
   int ed[$], hd[$]; // Rising-edge counts at which those notes fall due
   int n_errors = 0, checks_done = 0, seed = 76, cyc_n = 0;
   hfts_top #(.DATA_W(8), .FIFO_DEPTH(4)) uut (.mclk, .rst_n, .reg_sel, .reg_rd, .reg_wr,
      .reg_addr, .reg_wdata, .reg_rdata, .receiver_enable_bit, .transmitter_enable_bit,
      .rx_bit_clock, .tx_bit_clock, .rx_crc_ok, .rx_addr_match, .rx_fifo_fill,
      .tx_fifo_fill, .rx_full_status, .tx_full_status, .rx_fifo_full_irq, .tx_fifo_low_irq,
      .rx_byte_valid, .rx_byte_ready, .rx_byte_data, .rx_out_valid, .rx_out_ready,
      .rx_out_data);
   assign flg = {4'h0, rx_full_status, tx_full_status, rx_fifo_full_irq, tx_fifo_low_irq};
   initial forever #5 mclk = ~mclk;
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One compare task for each kind of result
   task automatic cmp_rd(input logic [7:0] e);
      check(reg_rdata, e);
   endtask
   task automatic cmp_flg(input logic [7:0] e);
      check(flg, e);
   endtask
   task automatic cmp_hs(input logic [1:0] e);
      check({6'h0, rx_out_valid, rx_byte_ready}, {6'h0, e});
   endtask
   task automatic cmp_byte(input logic [7:0] e);
      check(rx_out_data, e);
   endtask
   // Notes a level result due lat rising edges from now; lat is at least one
   task automatic expect_flg(input int lat, input logic [7:0] e);
      eq.push_back(e);
      ed.push_back(cyc_n + lat);
   endtask
   task automatic expect_hs(input logic [1:0] e);
      hq.push_back(e);
      hd.push_back(cyc_n + 1);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // Strobes are only raised here and dropped by idle, never twice in one step
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      reg_sel = 1'b1;
      reg_wr = 1'b1;
      reg_rd = 1'b0;
      reg_addr = a;
      reg_wdata = d;
      cyc(1);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      reg_sel = 1'b1;
      reg_rd = 1'b1;
      reg_wr = 1'b0;
      reg_addr = a;
      rq.push_back(e);
      cyc(1);
   endtask
   task automatic idle();
      reg_sel = 1'b0;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
   endtask
   // Ready only moves at the edge, so its value now tells whether the byte is taken
   // A refused byte is offered again unchanged until the edge that takes it
   task automatic push(input logic v);
      if (!in_stall) begin
         rx_byte_valid = v;
         rx_byte_data = 8'($random(seed));
      end
      if (rx_byte_valid && rx_byte_ready)
         fq.push_back(rx_byte_data);
      cyc(1);
   endtask
   task automatic tally_and_finish();
      // Notes never compared mean a result never appeared
      if (rq.size() + fq.size() + eq.size() + hq.size() > 0)
         n_errors++;
      $display("comparisons %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Watchers: read data lands at the read edge and is compared at the next falling edge
   always @(posedge mclk) begin
      rd_taken <= reg_sel && reg_rd;
      in_stall <= rx_byte_valid && !rx_byte_ready;
      cyc_n <= cyc_n + 1;
      if (rx_out_valid && rx_out_ready)
         cmp_byte(fq.pop_front());
   end
   // Level notes are taken off when their edge count comes round
   always @(negedge mclk) begin
      if (rd_taken)
         cmp_rd(rq.pop_front());
      if (ed.size() > 0 && ed[0] == cyc_n) begin
         void'(ed.pop_front());
         cmp_flg(eq.pop_front());
      end
      if (hd.size() > 0 && hd[0] == cyc_n) begin
         void'(hd.pop_front());
         cmp_hs(hq.pop_front());
      end
   end
   initial begin
      #20us;
      n_errors++;
      tally_and_finish();
   end
   initial begin
      cyc(10);
      rst_n = 1'b1;
      expect_flg(2, 8'h01);
      cyc(2);
      rd(5'h1d, 8'h00);
      rd(5'h1e, 8'h00);
      rd(5'h05, 8'h00);
      wr(5'h1c, 8'hff);
      rd(5'h1c, 8'h00);
      idle();
      $display("reset and refusal test done");
      // Every code in every field, fills on both sides of each boundary
      for (int i = 0; i < 8; i++) begin
         r = 8'($random(seed));
         lv = {r[7], 3'(i), r[3], 3'(7 - i)};
         th = {r[3], 3'(7 - i), r[7], 3'(i)};
         wr(5'h1d, lv);
         wr(5'h1e, th);
         rd(5'h1d, lv & 8'h77);
         rd(5'h1e, th & 8'h77);
         idle();
         for (int j = 0; j < 4; j++) begin
            rx_fifo_fill = 8'((j < 2 ? 16 * (lv[6:4] + 1) : 64 + 8 * th[6:4]) + j % 2 - 1);
            tx_fifo_fill = 8'(j < 2 ? 16 * (lv[2:0] + 1) - 1 + j : 8 * (th[2:0] + 1) + j - 2);
            ef = {4'h0, rx_fifo_fill >= 16 * (lv[6:4] + 1), tx_fifo_fill >= 16 * (lv[2:0] + 1),
               rx_fifo_fill >= 64 + 8 * th[6:4], tx_fifo_fill <= 8 * (th[2:0] + 1)};
            expect_flg(2, ef);
            cyc(2);
         end
      end
      $display("level and threshold test done");
      for (int i = 0; i < 8; i++) begin
         r = 8'($random(seed));
         {receiver_enable_bit, transmitter_enable_bit, rx_bit_clock, tx_bit_clock} = r[5:2];
         {rx_crc_ok, rx_addr_match} = r[1:0];
         cyc(5);
         rd(5'h1c, {4'h0, r[5] & r[3], r[4] & r[2], r[1:0]});
         idle();
      end
      $display("test status test done");
      for (int i = 0; i < 5; i++)
         push(1'b1);
      expect_hs(2'b10);
      cyc(1);
      for (int i = 0; i < 40; i++) begin
         rx_out_ready = 1'($random(seed));
         push(1'($random(seed)));
      end
      rx_out_ready = 1'b1;
      for (int i = 0; i < 6; i++)
         push(1'b0);
      expect_hs(2'b01);
      $display("staging buffer test done");
      cyc(3);
      tally_and_finish();
   end
endmodule
`default_nettype wire
